// ===== hw/smps_pkg.sv
package smps_pkg;

	// ****************************************
	// Register indices and bus address width
	// ****************************************
	localparam logic [11:0] STATUS_SELECT_IDX = 12'h017;
	localparam logic [11:0] MON_SELECT_IDX = 12'h018;
	localparam logic [11:0] LIVE_FLAGS_IDX = 12'h019;
	localparam logic [11:0] IRQ_STATUS_IDX = 12'h01A;
	localparam logic [11:0] IRQ_MASK_IDX = 12'h01B;
	localparam int ADDR_W = 14;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int STATUS_CODE_LSB = 0;
	localparam int STATUS_CODE_W = 6;
	localparam int STATUS_DIV_EN_BIT = 6;
	localparam int MON_CODE_LSB = 0;
	localparam int MON_CODE_W = 5;

	// Flag vector layout
	localparam int FLAG_W = 9;
	localparam int FL_LOCK = 0;
	localparam int FL_REF1_PRES = 1;
	localparam int FL_REF2_PRES = 2;
	localparam int FL_SEL_PRES = 3;
	localparam int FL_UNSEL_PRES = 4;
	localparam int FL_FB_PRES = 5;
	localparam int FL_REF_SEL = 6;
	localparam int FL_REF1_FREQ = 7;
	localparam int FL_REF2_FREQ = 8;

	// Event bits
	localparam int EV_W = 4;
	localparam int EV_LOCK_LOST = 0;
	localparam int EV_REFS_MISSING = 1;
	localparam int EV_FB_LOST = 2;
	localparam int EV_REF_SWITCH = 3;

	// ****************************************
	// Reset values and bus response codes
	// ****************************************
	localparam logic [7:0] STATUS_SELECT_RST = 8'h00;
	localparam logic [7:0] MON_SELECT_RST = 8'h00;
	localparam logic [3:0] IRQ_MASK_RST = 4'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [0:0] {
		SMPS_IDLE = 1'b0,
		SMPS_RESP = 1'b1
	} smps_bus_state_t;

endpackage

// ===== hw/smps_mux.sv
module smps_mux (
	// Select codes
	input wire logic [5:0] status_code,
	input wire logic [4:0] mon_code,
	// Sources
	input wire logic [8:0] flags,
	input wire logic first_reference_input,
	input wire logic second_reference_input,
	input wire logic sel_ref_clk,
	input wire logic unsel_ref_clk,
	// Pins
	output logic status_pin,
	output logic reference_monitor_pin
);

	// ****************************************
	// Derived terms
	// ****************************************
	wire logic lock_term;
	wire logic both_missing;
	wire logic pll_supply_level;
	wire logic lkd;
	wire logic fb;
	wire logic rsel;
	assign lkd = flags[smps_pkg::FL_LOCK];
	assign fb = flags[smps_pkg::FL_FB_PRES];
	assign rsel = flags[smps_pkg::FL_REF_SEL];
	assign pll_supply_level = 1'b1;
	assign lock_term = lkd & flags[smps_pkg::FL_SEL_PRES] & fb;
	assign both_missing = ~flags[smps_pkg::FL_REF1_PRES] & ~flags[smps_pkg::FL_REF2_PRES];

	// Pure selection, no clock: glitches on code change are possible
	always_comb begin
		case (status_code)
			6'h2A: status_pin = lock_term;
			6'h2B: status_pin = fb;
			6'h2C: status_pin = rsel;
			6'h2D: status_pin = lkd;
			6'h30, 6'h3F: status_pin = pll_supply_level;
			6'h31: status_pin = first_reference_input;
			6'h32: status_pin = second_reference_input;
			6'h33: status_pin = sel_ref_clk;
			6'h34: status_pin = unsel_ref_clk;
			6'h35: status_pin = ~flags[smps_pkg::FL_SEL_PRES];
			6'h36: status_pin = ~both_missing;
			6'h37: status_pin = ~flags[smps_pkg::FL_REF1_PRES];
			6'h38: status_pin = ~flags[smps_pkg::FL_REF2_PRES];
			6'h39: status_pin = flags[smps_pkg::FL_REF1_PRES] & flags[smps_pkg::FL_REF2_PRES];
			6'h3A: status_pin = ~lock_term;
			6'h3B: status_pin = ~fb;
			6'h3C: status_pin = ~rsel;
			6'h3D: status_pin = ~lkd;
			6'h21: status_pin = first_reference_input;
			6'h22: status_pin = second_reference_input;
			6'h23: status_pin = sel_ref_clk;
			6'h24: status_pin = unsel_ref_clk;
			6'h25: status_pin = both_missing;
			6'h27: status_pin = flags[smps_pkg::FL_REF1_PRES];
			6'h28: status_pin = flags[smps_pkg::FL_REF2_PRES];
			6'h29: status_pin = flags[smps_pkg::FL_REF1_PRES] & flags[smps_pkg::FL_REF2_PRES];
			default: status_pin = 1'b0;
		endcase
	end

	// Bits 7:5 of the register never reach this decoder
	always_comb begin
		case (mon_code)
			5'h00, 5'h06: reference_monitor_pin = 1'b0;
			5'h01: reference_monitor_pin = first_reference_input;
			5'h02: reference_monitor_pin = second_reference_input;
			5'h03: reference_monitor_pin = sel_ref_clk;
			5'h04: reference_monitor_pin = unsel_ref_clk;
			5'h05: reference_monitor_pin = both_missing;
			5'h07: reference_monitor_pin = flags[smps_pkg::FL_REF1_FREQ];
			5'h08: reference_monitor_pin = flags[smps_pkg::FL_REF2_FREQ];
			5'h09, 5'h19: reference_monitor_pin =
				flags[smps_pkg::FL_REF1_FREQ] & flags[smps_pkg::FL_REF2_FREQ];
			5'h0A, 5'h1A: reference_monitor_pin = lock_term;
			5'h0B: reference_monitor_pin = fb;
			5'h0C: reference_monitor_pin = rsel;
			5'h0D: reference_monitor_pin = lkd;
			5'h10, 5'h1F: reference_monitor_pin = pll_supply_level;
			5'h11: reference_monitor_pin = first_reference_input;
			5'h12: reference_monitor_pin = second_reference_input;
			5'h13: reference_monitor_pin = sel_ref_clk;
			5'h14: reference_monitor_pin = unsel_ref_clk;
			5'h15: reference_monitor_pin = ~flags[smps_pkg::FL_SEL_PRES];
			5'h16: reference_monitor_pin = ~flags[smps_pkg::FL_UNSEL_PRES];
			5'h17: reference_monitor_pin = ~flags[smps_pkg::FL_REF1_FREQ];
			5'h18: reference_monitor_pin = ~flags[smps_pkg::FL_REF2_FREQ];
			5'h1B: reference_monitor_pin = ~fb;
			5'h1C: reference_monitor_pin = ~rsel;
			5'h1D: reference_monitor_pin = ~lkd;
			default: reference_monitor_pin = 1'b0;
		endcase
	end

endmodule

// ===== hw/smps_top.sv
module smps_top (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// AXI4-Lite write address
	input wire logic [13:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [13:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// PLL status flags, asynchronous levels
	input wire logic digital_lock_detect,
	input wire logic ref1_present,
	input wire logic ref2_present,
	input wire logic sel_ref_present,
	input wire logic unsel_ref_present,
	input wire logic fb_clk_present,
	input wire logic ref_sel_second,
	input wire logic ref1_freq_ok,
	input wire logic ref2_freq_ok,
	// Reference clocks
	input wire logic first_reference_input,
	input wire logic second_reference_input,
	input wire logic sel_ref_clk,
	input wire logic unsel_ref_clk,
	// Monitor pins and controls
	output logic status_pin,
	output logic reference_monitor_pin,
	output logic status_div_en,
	// Interrupt
	output logic irq
);

	// ****************************************
	// Address helpers
	// ****************************************
	function automatic logic [13:0] reg_addr(input logic [11:0] idx);
		reg_addr = {idx, 2'b00};
	endfunction

	function automatic logic word_hit(input logic [13:0] addr, input logic [11:0] idx);
		word_hit = (addr[13:2] == idx);
	endfunction

	// ****************************************
	// Declarations
	// ****************************************
	logic [7:0] status_select_q;
	logic [7:0] status_select_d;
	logic [7:0] mon_select_q;
	logic [7:0] mon_select_d;
	logic [3:0] irq_mask_q;
	logic [3:0] irq_mask_d;
	logic [3:0] irq_status_q;
	logic [3:0] irq_status_d;
	logic [8:0] meta_q;
	logic [8:0] flags_q;
	logic [8:0] flags_prev_q;
	logic [13:0] awaddr_q;
	logic aw_have_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic w_have_q;
	smps_pkg::smps_bus_state_t wr_state_q;
	smps_pkg::smps_bus_state_t wr_state_d;
	smps_pkg::smps_bus_state_t rd_state_q;
	smps_pkg::smps_bus_state_t rd_state_d;
	logic [1:0] bresp_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	wire logic [8:0] raw_flags;
	wire logic aw_take;
	wire logic w_take;
	wire logic ar_take;
	wire logic wr_fire;
	wire logic [13:0] wr_addr;
	wire logic [31:0] wr_data;
	wire logic wr_lane0;
	wire logic hit_w_status;
	wire logic hit_w_refmon;
	wire logic hit_w_mask;
	wire logic hit_w_any;
	wire logic hit_r_status;
	wire logic hit_r_refmon;
	wire logic hit_r_live;
	wire logic hit_r_irq;
	wire logic hit_r_mask;
	wire logic hit_r_any;
	wire logic [31:0] rd_value;
	wire logic [3:0] events;
	wire logic both_missing_now;
	wire logic both_missing_prev;
	wire logic irq_rd_clear;

	// ****************************************
	// Flag synchronisers
	// ****************************************
	assign raw_flags = {ref2_freq_ok, ref1_freq_ok, ref_sel_second, fb_clk_present,
		unsel_ref_present, sel_ref_present, ref2_present, ref1_present, digital_lock_detect};

	// Only the second stage feeds the live flag read; it and the third stage (flags_prev_q) feed the event logic
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			meta_q <= 9'h000;
			flags_q <= 9'h000;
			flags_prev_q <= 9'h000;
		end else begin
			meta_q <= raw_flags;
			flags_q <= meta_q;
			flags_prev_q <= flags_q;
		end
	end

	// ****************************************
	// Pin selection
	// ****************************************
	// Raw flags drive the pins: an observer sees them with no sampling delay
	smps_mux u_mux (
		.status_code(status_select_q[smps_pkg::STATUS_CODE_LSB +: smps_pkg::STATUS_CODE_W]),
		.mon_code(mon_select_q[smps_pkg::MON_CODE_LSB +: smps_pkg::MON_CODE_W]),
		.flags(raw_flags),
		.first_reference_input(first_reference_input),
		.second_reference_input(second_reference_input),
		.sel_ref_clk(sel_ref_clk),
		.unsel_ref_clk(unsel_ref_clk),
		.status_pin(status_pin),
		.reference_monitor_pin(reference_monitor_pin)
	);

	// Divider itself lives elsewhere; only the enable bit is kept here
	assign status_div_en = status_select_q[smps_pkg::STATUS_DIV_EN_BIT];

	// ****************************************
	// Write channel
	// ****************************************
	assign s_axi_awready = ~aw_have_q & (wr_state_q == smps_pkg::SMPS_IDLE);
	assign s_axi_wready = ~w_have_q & (wr_state_q == smps_pkg::SMPS_IDLE);
	assign aw_take = s_axi_awvalid & s_axi_awready;
	assign w_take = s_axi_wvalid & s_axi_wready;
	assign wr_addr = aw_take ? s_axi_awaddr : awaddr_q;
	assign wr_data = w_take ? s_axi_wdata : wdata_q;
	assign wr_lane0 = w_take ? s_axi_wstrb[0] : wstrb_q[0];
	assign wr_fire = (wr_state_q == smps_pkg::SMPS_IDLE) & (aw_take | aw_have_q)
		& (w_take | w_have_q);

	assign hit_w_status = word_hit(wr_addr, smps_pkg::STATUS_SELECT_IDX);
	assign hit_w_refmon = word_hit(wr_addr, smps_pkg::MON_SELECT_IDX);
	assign hit_w_mask = word_hit(wr_addr, smps_pkg::IRQ_MASK_IDX);
	assign hit_w_any = hit_w_status | hit_w_refmon | hit_w_mask
		| word_hit(wr_addr, smps_pkg::LIVE_FLAGS_IDX) | word_hit(wr_addr, smps_pkg::IRQ_STATUS_IDX);

	assign status_select_d = (wr_fire & hit_w_status & wr_lane0) ? wr_data[7:0] : status_select_q;
	// All eight bits stored, only the low five decoded
	assign mon_select_d = (wr_fire & hit_w_refmon & wr_lane0) ? wr_data[7:0]
		: mon_select_q;
	assign irq_mask_d = (wr_fire & hit_w_mask & wr_lane0) ? wr_data[3:0] : irq_mask_q;

	always_comb begin
		wr_state_d = wr_state_q;
		case (wr_state_q)
			smps_pkg::SMPS_IDLE: begin
				if (wr_fire) begin
					wr_state_d = smps_pkg::SMPS_RESP;
				end
			end
			smps_pkg::SMPS_RESP: begin
				if (s_axi_bready) begin
					wr_state_d = smps_pkg::SMPS_IDLE;
				end
			end
			default: wr_state_d = smps_pkg::SMPS_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wr_state_q <= smps_pkg::SMPS_IDLE;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= 14'h0000;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			bresp_q <= smps_pkg::RESP_OKAY;
		end else begin
			wr_state_q <= wr_state_d;
			aw_have_q <= wr_fire ? 1'b0 : (aw_have_q | aw_take);
			w_have_q <= wr_fire ? 1'b0 : (w_have_q | w_take);
			if (aw_take) begin
				awaddr_q <= s_axi_awaddr;
			end
			if (w_take) begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_fire) begin
				bresp_q <= hit_w_any ? smps_pkg::RESP_OKAY : smps_pkg::RESP_SLVERR;
			end
		end
	end

	assign s_axi_bvalid = (wr_state_q == smps_pkg::SMPS_RESP);
	assign s_axi_bresp = bresp_q;

	// ****************************************
	// Read channel
	// ****************************************
	assign s_axi_arready = (rd_state_q == smps_pkg::SMPS_IDLE);
	assign ar_take = s_axi_arvalid & s_axi_arready;
	assign hit_r_status = word_hit(s_axi_araddr, smps_pkg::STATUS_SELECT_IDX);
	assign hit_r_refmon = word_hit(s_axi_araddr, smps_pkg::MON_SELECT_IDX);
	assign hit_r_live = word_hit(s_axi_araddr, smps_pkg::LIVE_FLAGS_IDX);
	assign hit_r_irq = word_hit(s_axi_araddr, smps_pkg::IRQ_STATUS_IDX);
	assign hit_r_mask = word_hit(s_axi_araddr, smps_pkg::IRQ_MASK_IDX);
	assign hit_r_any = hit_r_status | hit_r_refmon | hit_r_live | hit_r_irq | hit_r_mask;
	assign rd_value = hit_r_status ? {24'h000000, status_select_q}
		: hit_r_refmon ? {24'h000000, mon_select_q}
		: hit_r_live ? {23'h000000, flags_q}
		: hit_r_irq ? {28'h0000000, irq_status_q}
		: hit_r_mask ? {28'h0000000, irq_mask_q}
		: 32'h00000000;
	assign irq_rd_clear = ar_take & hit_r_irq;

	always_comb begin
		rd_state_d = rd_state_q;
		case (rd_state_q)
			smps_pkg::SMPS_IDLE: begin
				if (ar_take) begin
					rd_state_d = smps_pkg::SMPS_RESP;
				end
			end
			smps_pkg::SMPS_RESP: begin
				if (s_axi_rready) begin
					rd_state_d = smps_pkg::SMPS_IDLE;
				end
			end
			default: rd_state_d = smps_pkg::SMPS_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rd_state_q <= smps_pkg::SMPS_IDLE;
			rdata_q <= 32'h00000000;
			rresp_q <= smps_pkg::RESP_OKAY;
		end else begin
			rd_state_q <= rd_state_d;
			if (ar_take) begin
				rdata_q <= rd_value;
				rresp_q <= hit_r_any ? smps_pkg::RESP_OKAY : smps_pkg::RESP_SLVERR;
			end
		end
	end

	assign s_axi_rvalid = (rd_state_q == smps_pkg::SMPS_RESP);
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	// ****************************************
	// Events and interrupt
	// ****************************************
	assign both_missing_now = ~flags_q[smps_pkg::FL_REF1_PRES] & ~flags_q[smps_pkg::FL_REF2_PRES];
	assign both_missing_prev = ~flags_prev_q[smps_pkg::FL_REF1_PRES]
		& ~flags_prev_q[smps_pkg::FL_REF2_PRES];
	assign events[smps_pkg::EV_LOCK_LOST] = flags_prev_q[smps_pkg::FL_LOCK]
		& ~flags_q[smps_pkg::FL_LOCK];
	assign events[smps_pkg::EV_REFS_MISSING] = both_missing_now & ~both_missing_prev;
	assign events[smps_pkg::EV_FB_LOST] = flags_prev_q[smps_pkg::FL_FB_PRES]
		& ~flags_q[smps_pkg::FL_FB_PRES];
	assign events[smps_pkg::EV_REF_SWITCH] = flags_prev_q[smps_pkg::FL_REF_SEL]
		^ flags_q[smps_pkg::FL_REF_SEL];

	// New event beats the read clear in the same cycle
	assign irq_status_d = (irq_rd_clear ? 4'h0 : irq_status_q) | events;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			status_select_q <= smps_pkg::STATUS_SELECT_RST;
			mon_select_q <= smps_pkg::MON_SELECT_RST;
			irq_mask_q <= smps_pkg::IRQ_MASK_RST;
			irq_status_q <= 4'h0;
		end else begin
			status_select_q <= status_select_d;
			mon_select_q <= mon_select_d;
			irq_mask_q <= irq_mask_d;
			irq_status_q <= irq_status_d;
		end
	end

	assign irq = |(irq_status_q & irq_mask_q);

endmodule

// ===== verification/smps_ref_src.sv
// Free-running reference clocks; offset so no edge meets a sys_clk edge or a mid-cycle sample
module smps_ref_src (
	// Selection
	input wire logic ref_sel_second,
	// Clocks
	output logic first_reference_input,
	output logic second_reference_input,
	output logic sel_ref_clk,
	output logic unsel_ref_clk
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		first_reference_input = 1'b0;
		#0.5;
		forever #7 first_reference_input = ~first_reference_input;
	end
	initial begin
		second_reference_input = 1'b1;
		#0.5;
		forever #11 second_reference_input = ~second_reference_input;
	end
	assign sel_ref_clk = ref_sel_second ? second_reference_input : first_reference_input;
	assign unsel_ref_clk = ref_sel_second ? first_reference_input : second_reference_input;
endmodule

// ===== verification/smps_top_sva.sv
module smps_top_sva (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Bus
	input wire logic [13:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// Sources
	input wire logic digital_lock_detect,
	input wire logic ref1_present,
	input wire logic ref2_present,
	input wire logic sel_ref_present,
	input wire logic fb_clk_present,
	input wire logic ref_sel_second,
	input wire logic first_reference_input,
	// Pins
	input wire logic status_pin,
	input wire logic reference_monitor_pin
);
	timeunit 1ns;
	timeprecision 100ps;
	// ****************************************
	// Shadow of select codes
	// ****************************************
	// Only joint address/data acceptance is tracked, which is how the bench drives
	logic [5:0] sc_q;
	logic [4:0] mc_q;
	wire wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];
	wire lock_all = digital_lock_detect && sel_ref_present && fb_clk_present;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sc_q <= 6'h00;
			mc_q <= 5'h00;
		end else if (wr_go && s_axi_awaddr == 14'h005C) begin
			sc_q <= s_axi_wdata[5:0];
		end else if (wr_go && s_axi_awaddr == 14'h0060) begin
			mc_q <= s_axi_wdata[4:0];
		end
	end
	// ****************************************
	// Properties
	// ****************************************
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence b_wait;
		s_axi_bvalid && !s_axi_bready;
	endsequence
	vdd_high_a: assert property ((sc_q == 6'h30 || sc_q == 6'h3F) |-> status_pin)
		else $error("status pin not high");
	ref_clk_a: assert property (sc_q == 6'h31 |-> status_pin == first_reference_input)
		else $error("status pin not first clock");
	fb_pres_a: assert property (sc_q == 6'h2B |-> status_pin == fb_clk_present)
		else $error("feedback level wrong");
	lock_and_a: assert property ((sc_q == 6'h2A || sc_q == 6'h3A)
		|-> status_pin == (lock_all ^ sc_q[4])) else $error("lock term wrong");
	ref_sel_a: assert property ((sc_q == 6'h2C || sc_q == 6'h3C)
		|-> status_pin == (ref_sel_second ^ sc_q[4])) else $error("selection wrong");
	sel_miss_a: assert property (sc_q == 6'h35 |-> status_pin == !sel_ref_present)
		else $error("selected presence wrong");
	both_miss_a: assert property (sc_q == 6'h36
		|-> status_pin == (ref1_present || ref2_present)) else $error("both missing wrong");
	mon_gnd_a: assert property ((mc_q == 5'h00 || mc_q == 5'h06)
		|-> !reference_monitor_pin) else $error("monitor pin not ground");
	mon_miss_a: assert property (mc_q == 5'h05
		|-> reference_monitor_pin == !(ref1_present || ref2_present)) else $error("monitor missing");
	wr_resp_a: assert property (wr_go |=> s_axi_bvalid)
		else $error("no write response");
	resp_hold_a: assert property (b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
endmodule

bind smps_top smps_top_sva chk (.sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
	.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.digital_lock_detect(digital_lock_detect), .ref1_present(ref1_present),
	.ref2_present(ref2_present), .sel_ref_present(sel_ref_present),
	.fb_clk_present(fb_clk_present), .ref_sel_second(ref_sel_second),
	.first_reference_input(first_reference_input), .status_pin(status_pin),
	.reference_monitor_pin(reference_monitor_pin));

// ===== verification/tb_status_monitor_pin_select.sv
module tb_status_monitor_pin_select;
	timeunit 1ns;
	timeprecision 100ps;
	// ****************************************
	// Signals
	// ****************************************
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [13:0] aw_addr = 14'h0000;
	logic [13:0] ar_addr = 14'h0000;
	logic [31:0] w_data = 32'h0000_0000;
	logic aw_valid = 1'b0;
	logic w_valid = 1'b0;
	logic b_ready = 1'b0;
	logic ar_valid = 1'b0;
	logic r_ready = 1'b0;
	logic [8:0] fl = 9'h000;
	logic aw_ready, w_ready, b_valid, ar_ready, r_valid, st_pin, mon_pin, div_en, irq;
	logic c1, c2, cs, cu;
	logic [1:0] b_resp, r_resp;
	logic [31:0] r_data, d;
	int n_errors = 0;
	int n_tests = 0;
	logic [5:0] sc_tab [19] = '{6'h30, 6'h3F, 6'h31, 6'h32, 6'h33, 6'h34, 6'h2B, 6'h2A,
		6'h3A, 6'h2C, 6'h3C, 6'h35, 6'h36, 6'h37, 6'h38, 6'h39, 6'h3B, 6'h2D, 6'h3D};
	logic [4:0] mc_tab [10] = '{5'h00, 5'h06, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h07, 5'h08,
		5'h09};
	logic [8:0] pat [5] = '{9'h1FF, 9'h000, 9'h155, 9'h0AA, 9'h03E};
	wire lk = fl[smps_pkg::FL_LOCK];
	wire ra = fl[smps_pkg::FL_REF1_PRES];
	wire rb = fl[smps_pkg::FL_REF2_PRES];
	wire sp = fl[smps_pkg::FL_SEL_PRES];
	wire fb = fl[smps_pkg::FL_FB_PRES];
	wire rs = fl[smps_pkg::FL_REF_SEL];
	wire fa = fl[smps_pkg::FL_REF1_FREQ];
	wire fq = fl[smps_pkg::FL_REF2_FREQ];
	always #10 sys_clk = ~sys_clk;
	smps_ref_src src (.ref_sel_second(rs), .first_reference_input(c1),
		.second_reference_input(c2), .sel_ref_clk(cs), .unsel_ref_clk(cu));
	smps_top dut (.sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(aw_addr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(aw_valid), .s_axi_awready(aw_ready), .s_axi_wdata(w_data),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(w_valid), .s_axi_wready(w_ready),
		.s_axi_bresp(b_resp), .s_axi_bvalid(b_valid), .s_axi_bready(b_ready),
		.s_axi_araddr(ar_addr), .s_axi_arprot(3'h0), .s_axi_arvalid(ar_valid),
		.s_axi_arready(ar_ready), .s_axi_rdata(r_data), .s_axi_rresp(r_resp),
		.s_axi_rvalid(r_valid), .s_axi_rready(r_ready), .digital_lock_detect(lk),
		.ref1_present(ra), .ref2_present(rb), .sel_ref_present(sp),
		.unsel_ref_present(fl[smps_pkg::FL_UNSEL_PRES]), .fb_clk_present(fb),
		.ref_sel_second(rs), .ref1_freq_ok(fa), .ref2_freq_ok(fq), .first_reference_input(c1),
		.second_reference_input(c2), .sel_ref_clk(cs), .unsel_ref_clk(cu), .status_pin(st_pin),
		.reference_monitor_pin(mon_pin), .status_div_en(div_en), .irq(irq));
	// ****************************************
	// Helpers
	// ****************************************
	task automatic stop_test();
		$display("errors %0d checks %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic ok, input string m);
		n_tests++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	// Every bus task starts and ends right after a rising edge
	// A late bready (bw cycles) lets the response wait; only the watchdog ends a wait
	task automatic wr(input logic [13:0] a, input logic [31:0] v, input logic [1:0] er,
		input int bw = 0);
		int n;
		logic got, ta, tw;
		logic [1:0] r;
		aw_addr <= a;
		w_data <= v;
		aw_valid <= 1'b1;
		w_valid <= 1'b1;
		b_ready <= (bw == 0);
		got = 1'b0;
		n = 0;
		while (!got) begin
			@(negedge sys_clk);
			n++;
			got = b_valid && b_ready;
			r = b_resp;
			ta = aw_valid && aw_ready;
			tw = w_valid && w_ready;
			@(posedge sys_clk);
			if (ta) aw_valid <= 1'b0;
			if (tw) w_valid <= 1'b0;
			if (!got && n >= bw) b_ready <= 1'b1;
		end
		b_ready <= 1'b0;
		@(posedge sys_clk);
		chk(got && r === er, "write response");
	endtask
	task automatic rd(input logic [13:0] a, input logic [1:0] er);
		logic got, ta;
		logic [1:0] r;
		ar_addr <= a;
		ar_valid <= 1'b1;
		r_ready <= 1'b1;
		got = 1'b0;
		while (!got) begin
			@(negedge sys_clk);
			got = r_valid;
			d = r_data;
			r = r_resp;
			ta = ar_valid && ar_ready;
			@(posedge sys_clk);
			if (ta) ar_valid <= 1'b0;
		end
		r_ready <= 1'b0;
		@(posedge sys_clk);
		chk(got && r === er, "read response");
	endtask
	function automatic logic exp_st(input logic [5:0] c);
		case (c)
			6'h30, 6'h3F: return 1'b1;
			6'h31: return c1;
			6'h32: return c2;
			6'h33: return cs;
			6'h34: return cu;
			6'h2B: return fb;
			6'h2A: return lk & sp & fb;
			6'h3A: return ~(lk & sp & fb);
			6'h2C: return rs;
			6'h3C: return ~rs;
			6'h35: return ~sp;
			6'h36: return ra | rb;
			6'h37: return ~ra;
			6'h38: return ~rb;
			6'h39: return ra & rb;
			6'h3B: return ~fb;
			6'h2D: return lk;
			6'h3D: return ~lk;
			default: return 1'b0;
		endcase
	endfunction
	function automatic logic exp_mon(input logic [4:0] c);
		case (c)
			5'h01: return c1;
			5'h02: return c2;
			5'h03: return cs;
			5'h04: return cu;
			5'h05: return ~(ra | rb);
			5'h07: return fa;
			5'h08: return fq;
			5'h09: return fa & fq;
			default: return 1'b0;
		endcase
	endfunction
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		chk(st_pin === 1'b0 && mon_pin === 1'b0 && irq === 1'b0, "reset pins");
		rd(14'h0060, smps_pkg::RESP_OKAY);
		chk(d === {24'h0, smps_pkg::MON_SELECT_RST}, "reset value");
	endtask
	task automatic t_status();
		for (int i = 0; i < 19; i++) begin
			wr(14'h005C, {26'h0, sc_tab[i]}, smps_pkg::RESP_OKAY);
			for (int p = 0; p < 5; p++) begin
				fl <= pat[p];
				repeat (3) begin
					@(negedge sys_clk);
					chk(st_pin === exp_st(sc_tab[i]), "status pin");
				end
				@(posedge sys_clk);
			end
		end
	endtask
	task automatic t_refmon();
		for (int i = 0; i < 10; i++) begin
			wr(14'h0060, {24'h0, 3'b101, mc_tab[i]}, smps_pkg::RESP_OKAY);
			for (int p = 0; p < 5; p++) begin
				fl <= pat[p];
				repeat (3) begin
					@(negedge sys_clk);
					chk(mon_pin === exp_mon(mc_tab[i]), "monitor pin");
				end
				@(posedge sys_clk);
			end
		end
	endtask
	task automatic t_regs();
		wr(14'h0060, 32'h0000_00E5, smps_pkg::RESP_OKAY, 3);
		rd(14'h0060, smps_pkg::RESP_OKAY);
		chk(d === 32'h0000_00E5, "monitor readback");
		// Divider enable follows bit 6 alone, whatever the code: 0x71 sets it, 0x30 clears it
		wr(14'h005C, 32'h0000_0071, smps_pkg::RESP_OKAY);
		chk(div_en === 1'b1 && st_pin === c1, "divider enable set");
		wr(14'h005C, 32'h0000_0030, smps_pkg::RESP_OKAY);
		chk(div_en === 1'b0 && st_pin === 1'b1, "divider enable clear");
		wr(14'h0200, 32'h0000_0031, smps_pkg::RESP_SLVERR);
		chk(st_pin === 1'b1, "unmapped write stored");
		rd(14'h0200, smps_pkg::RESP_SLVERR);
		chk(d === 32'h0, "unmapped read data");
	endtask
	task automatic t_irq(input logic [3:0] m);
		fl <= 9'h1FF;
		wr(14'h006C, {28'h0, m}, smps_pkg::RESP_OKAY);
		repeat (6) @(posedge sys_clk);
		rd(14'h0068, smps_pkg::RESP_OKAY);
		fl <= 9'h1FE;
		repeat (6) @(posedge sys_clk);
		@(negedge sys_clk);
		chk(irq === m[0], "irq on lock loss");
		@(posedge sys_clk);
		rd(14'h0068, smps_pkg::RESP_OKAY);
		chk(d[0] === 1'b1, "lock lost status");
		rd(14'h0068, smps_pkg::RESP_OKAY);
		chk(d[0] === 1'b0 && irq === 1'b0, "status cleared by read");
	endtask
	// ****************************************
	// Main sequence and watchdog
	// ****************************************
	initial begin
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		t_reset();
		t_status();
		t_refmon();
		t_regs();
		t_irq(4'h1);
		t_irq(4'h0);
		stop_test();
	end
	initial begin
		#200us;
		n_errors++;
		stop_test();
	end
endmodule
